// File: verilog/scps_defs.svh
// Purpose: Constants for the serial control port slave
// Assumes: Included by bare name from the slave module only
// Notes:   Mode codes, field positions, bit counts, address step and reset values only
// Summary of operation
// - Two select pins pick one of four port modes
// - Timing pin low first style, high second style
// - Serial mode is slave only; host drives clock
// - Every byte shifts most significant bit first
// - First command byte: direction, six zeros, A7
// - Second command byte: A6..A0 then burst flag
// - Burst read advances address after each byte
// - Burst write advances address after each byte
// - Chip select release ends access, drops bits
// - Partial write byte never reaches the register
// - Burst read prefetches next register during last bit
// - Write data follows commands; burst goes upward
// - Address counter wraps from FFh to 00h
// - Read returns addressed byte, burst continues upward
// - Half duplex, timed only by host clock
`ifndef SCPS_DEFS_SVH
`define SCPS_DEFS_SVH

// Port mode select codes
`define SCPS_MODE_MUX_PAR    2'h0
`define SCPS_MODE_NONMUX_PAR 2'h1
`define SCPS_MODE_SERIAL     2'h2
`define SCPS_MODE_HW_PIN     2'h3

// Command byte fields
`define SCPS_CMD_DIR_BIT     7
`define SCPS_CMD_A7_BIT      0
`define SCPS_CMD_BURST_BIT   0
`define SCPS_BIT_LAST        3'h7
`define SCPS_ADDR_STEP       8'h01

// Reset values
`define SCPS_ADDR_RST        8'h00
`define SCPS_BYTE_RST        8'h00
`define SCPS_SYNC_RST        5'h1F

`endif

// File: verilog/scps_pkg.sv
// Purpose: Types shared by the serial control port slave
// Assumes: Constants live in scps_defs.svh
// Notes:   Only types here
package scps_pkg;

  // Decoded port mode
  typedef enum logic [1:0] {SCPS_MUX_PAR, SCPS_NONMUX_PAR, SCPS_SERIAL, SCPS_HW_PIN} scps_mode_t;

  // Transfer phase of the serial link
  typedef enum logic [1:0] {SCPS_ST_IDLE, SCPS_ST_CMD2, SCPS_ST_DATA, SCPS_ST_DONE} scps_state_t;

  // Request toward the internal register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scps_reg_req_t;

  // Link pins as seen after synchronising
  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
    logic cpol;
    logic cpha;
  } scps_link_t;

endpackage

// File: verilog/scps_slave.sv
// Purpose: Control port mode decode and serial register access slave
// Assumes: Register file answers a read strobe with data one cycle later
// Notes:   Link pins are sampled on ref_clk; host clock must be slow enough
`timescale 1ns/1ns
`include "scps_defs.svh"

module scps_slave (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // Mode straps
  input  wire logic [1:0]             port_select_pins,
  input  wire logic                   parallel_timing_select,
  output scps_pkg::scps_mode_t        port_mode,
  output logic                        bus_style_second,
  // Serial link pins
  input  wire logic                   sck,
  input  wire logic                   mosi,
  input  wire logic                   cs_n,
  input  wire logic                   cpol,
  input  wire logic                   cpha,
  output logic                        miso,
  output logic                        miso_oe,
  // Internal register file
  output scps_pkg::scps_reg_req_t     reg_req,
  input  wire logic [7:0]             reg_rd_data
);
  import scps_pkg::*;

  logic [4:0]    sync_st1;
  logic [4:0]    sync_st2;
  logic [4:0]    sync_st3;
  scps_link_t    link;
  logic          sck_prev;
  logic          sck_rise;
  logic          sck_fall;
  logic          lead_edge;
  logic          trail_edge;
  logic          sample_edge;
  logic          shift_edge;
  logic          active;
  logic          byte_done;
  logic [2:0]    bit_cnt;
  logic [7:0]    rx_sr;
  logic [7:0]    next_rx;
  logic [7:0]    tx_sr;
  logic          rd_pending;
  logic          is_read;
  logic          burst;
  logic [7:0]    addr;
  scps_state_t   state;

  // Advance the register address, wrapping at the top of the map
  function automatic logic [7:0] addr_inc(input logic [7:0] a);
    addr_inc = a + `SCPS_ADDR_STEP;
  endfunction

  // Mode decode is registered so straps glitching do not ripple through
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      port_mode        <= SCPS_HW_PIN;
      bus_style_second <= 1'b0;
    end
    else
    begin
      case (port_select_pins)
        `SCPS_MODE_MUX_PAR:    port_mode <= SCPS_MUX_PAR;
        `SCPS_MODE_NONMUX_PAR: port_mode <= SCPS_NONMUX_PAR;
        `SCPS_MODE_SERIAL:     port_mode <= SCPS_SERIAL;
        default:               port_mode <= SCPS_HW_PIN;
      endcase
      bus_style_second <= parallel_timing_select;
    end
  end

  // Three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sync_st1 <= `SCPS_SYNC_RST;
      sync_st2 <= `SCPS_SYNC_RST;
      sync_st3 <= `SCPS_SYNC_RST;
      link     <= `SCPS_SYNC_RST;
      sck_prev <= 1'b1;
    end
    else
    begin
      sync_st1 <= {sck, mosi, cs_n, cpol, cpha};
      sync_st2 <= sync_st1;
      sync_st3 <= sync_st2;
      link     <= (link & (sync_st2 ^ sync_st3)) | (sync_st3 & ~(sync_st2 ^ sync_st3));
      sck_prev <= link.sck;
    end
  end

  // Edge roles follow the phase and polarity straps
  assign sck_rise    = link.sck & ~sck_prev;
  assign sck_fall    = ~link.sck & sck_prev;
  assign lead_edge   = link.cpol ? sck_fall : sck_rise;
  assign trail_edge  = link.cpol ? sck_rise : sck_fall;
  assign sample_edge = link.cpha ? trail_edge : lead_edge;
  assign shift_edge  = link.cpha ? lead_edge : trail_edge;
  assign active      = (port_mode == SCPS_SERIAL) && !link.cs_n;
  assign byte_done   = active && sample_edge && (bit_cnt == `SCPS_BIT_LAST);
  assign next_rx     = {rx_sr[6:0], link.mosi};

  // Receive shifter; counter clears with chip select so partial bytes vanish
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      bit_cnt <= 3'h0;
      rx_sr   <= `SCPS_BYTE_RST;
    end
    else if (!active)
    begin
      bit_cnt <= 3'h0;
      rx_sr   <= `SCPS_BYTE_RST;
    end
    else if (sample_edge)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sr   <= next_rx;
    end
  end

  // Command decode, address counter and register strobes
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state   <= SCPS_ST_IDLE;
      is_read <= 1'b0;
      burst   <= 1'b0;
      addr    <= `SCPS_ADDR_RST;
      reg_req <= '0;
    end
    else
    begin
      reg_req.wr <= 1'b0;
      reg_req.rd <= 1'b0;
      if (!active)
        state <= SCPS_ST_IDLE;
      else if (byte_done)
      begin
        case (state)
          SCPS_ST_IDLE:
          begin
            is_read  <= next_rx[`SCPS_CMD_DIR_BIT];
            addr[7]  <= next_rx[`SCPS_CMD_A7_BIT];
            state    <= SCPS_ST_CMD2;
          end
          SCPS_ST_CMD2:
          begin
            addr[6:0] <= next_rx[7:1];
            burst     <= next_rx[`SCPS_CMD_BURST_BIT];
            state     <= SCPS_ST_DATA;
            if (is_read)
            begin
              reg_req.rd   <= 1'b1;
              reg_req.addr <= {addr[7], next_rx[7:1]};
            end
          end
          SCPS_ST_DATA:
          begin
            if (!is_read)
            begin
              reg_req.wr    <= 1'b1;
              reg_req.addr  <= addr;
              reg_req.wdata <= next_rx;
            end
            if (!burst)
              state <= SCPS_ST_DONE;
            else
            begin
              addr <= addr_inc(addr);
              if (is_read)
              begin
                reg_req.rd   <= 1'b1;
                reg_req.addr <= addr_inc(addr);
              end
            end
          end
          SCPS_ST_DONE:
            state <= SCPS_ST_DONE; // Extra bytes after a single access are ignored
          default:
            state <= SCPS_ST_IDLE;
        endcase
      end
    end
  end

  // Transmit shifter; loaded from the fetch, drained on the shift edge
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rd_pending <= 1'b0;
      tx_sr      <= `SCPS_BYTE_RST;
      miso       <= 1'b0;
    end
    else
    begin
      rd_pending <= reg_req.rd;
      if (!active)
      begin
        tx_sr <= `SCPS_BYTE_RST;
        miso  <= 1'b0;
      end
      else if (rd_pending)
        tx_sr <= reg_rd_data;
      else if (shift_edge)
      begin
        miso  <= tx_sr[7];
        tx_sr <= {tx_sr[6:0], 1'b0};
      end
    end
  end

  // Drive the data pin only while returning read data
  assign miso_oe = active && is_read && ((state == SCPS_ST_DATA) || (state == SCPS_ST_DONE));

  // Skip the edge right after reset, where the decode still shows its reset value
  property p_mode;
    @(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> (port_mode == scps_mode_t'($past(port_select_pins)));
  endproperty
  AST_MODE_DECODE: assert property (p_mode) else $error("port mode mismatch");

  AST_TIMING_STYLE: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) |-> (bus_style_second == $past(parallel_timing_select)))
    else $error("bus style mismatch");

  // Watches the raw pin so the synchroniser delay is covered too
  AST_MISO_FLOAT: assert property (@(posedge ref_clk) disable iff (!nrst)
    cs_n [*6] |-> !miso_oe) else $error("data pin driven while deselected");

  AST_WRITE_ONLY_FULL: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_req.wr |-> $past(byte_done) && !$past(is_read)) else $error("write without full byte");

  AST_ADDR_WRAP: assert property (@(posedge ref_clk) disable iff (!nrst)
    (byte_done && state == SCPS_ST_DATA && burst) |=> addr == addr_inc($past(addr)))
    else $error("address did not step");

  AST_FETCH_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_req.rd && active) ##1 active |=> tx_sr == $past(reg_rd_data)) else $error("fetch not loaded");

  AST_HALF_DUPLEX: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(reg_req.wr && reg_req.rd)) else $error("read and write together");

  AST_CS_END: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(link.cs_n) |=> state == SCPS_ST_IDLE && bit_cnt == 3'h0) else $error("access not ended");

  AST_SINGLE_STOP: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == SCPS_ST_DONE) |=> !reg_req.wr && !reg_req.rd) else $error("access after single");

  COV_BURST_WRITE: cover property (@(posedge ref_clk) disable iff (!nrst)
    reg_req.wr ##[1:200] reg_req.wr);
  COV_BURST_READ: cover property (@(posedge ref_clk) disable iff (!nrst)
    reg_req.rd ##[1:200] reg_req.rd);
  COV_ABORT_MID: cover property (@(posedge ref_clk) disable iff (!nrst)
    (active && bit_cnt == 3'h4) ##1 !active);

endmodule

// File: verif/scps_host.sv
// Purpose: Host master model for the serial control port
// Assumes: Half link period of four ref_clk cycles, 80 ns per bit
// Notes:   Takes each returned bit just before the next shift edge
`timescale 1ns/1ns
module scps_host (
  // Clock
  input  wire logic ref_clk,
  // Strap view of the slave
  input  wire logic cpol,
  input  wire logic cpha,
  // Link pins
  output logic      sck,
  output logic      mosi,
  output logic      cs_n,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic mosi_bit;
  logic idle_tog;
  logic line;

  // Released lines toggle so a stale bit never passes for data
  assign mosi = cs_n ? idle_tog : mosi_bit;
  assign line = miso_oe ? miso : idle_tog;

  // Link at rest, idle pattern runs every cycle
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi_bit = 1'b0;
    idle_tog = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      idle_tog <= ~idle_tog;
    end
  end

  // Half a link clock period
  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask

  // One frame; ends wherever the caller says, no clear-on-read place here
  task automatic xfer(input int n, input logic [7:0] tx [6], output logic [7:0] rx [6]);
    rx = '{default: 8'h00};
    @(posedge ref_clk);
    sck <= cpol;
    repeat (8) @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      if (cpha)
        sck <= ~cpol;
      mosi_bit <= tx[i / 8][7 - i % 8];
      half();
      sck <= cpha ? cpol : ~cpol;
      half();
      rx[i / 8][7 - i % 8] = line;
      if (!cpha)
        sck <= cpol;
    end
    half();
    cs_n <= 1'b1;
  endtask
endmodule

// File: verif/tb.sv
// Purpose: Self-checking bench for the serial control port slave
// Assumes: Register file answers one cycle after a read strobe
// Notes:   Random addresses and data from a fixed seed, corners by hand
`timescale 1ns/1ns
module tb;
  import scps_pkg::*;
  logic          ref_clk, nrst, par_t, style;
  logic          sck, mosi, cs_n, cpol, cpha, miso, miso_oe;
  logic [1:0]    sel;
  scps_mode_t    mode;
  scps_reg_req_t req;
  logic [7:0]    rd_data;
  logic [7:0]    mem [256];
  logic [7:0]    shadow [256];
  logic [7:0]    tx [6];
  logic [7:0]    rx [6];
  int            error_cnt = 0;
  int            checks = 0;
  int            rd_cnt = 0;

  scps_slave dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .port_select_pins(sel),
    .parallel_timing_select(par_t), .port_mode(mode), .bus_style_second(style),
    .sck(sck), .mosi(mosi), .cs_n(cs_n), .cpol(cpol), .cpha(cpha),
    .miso(miso), .miso_oe(miso_oe), .reg_req(req), .reg_rd_data(rd_data)
  );
  scps_host host_u (
    .ref_clk(ref_clk), .cpol(cpol), .cpha(cpha), .sck(sck), .mosi(mosi),
    .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe)
  );

  // 100 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever
      #5 ref_clk = ~ref_clk;
  end

  // Register file; junk outside read cycles exposes a late capture
  always @(posedge ref_clk)
  begin
    if (req.wr === 1'b1)
      mem[req.addr] <= req.wdata;
    if (req.rd === 1'b1)
      rd_cnt++;
    rd_data <= (req.rd === 1'b1) ? mem[req.addr] : 8'($urandom);
  end

  // Command bytes: direction, six zeros, address, burst flag
  function automatic logic [15:0] cmd(input logic rd, input logic [7:0] a, input logic b);
    return {rd, 6'h00, a, b};
  endfunction

  // Case-equal compare of one byte
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counts, then the verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One frame; only whole data bytes count toward the expectation
  task automatic frame(input logic rd, input logic [7:0] a, input logic b, input int n);
    logic [7:0] x;
    {tx[0], tx[1]} = cmd(rd, a, b);
    for (int i = 2; i < 6; i++)
      tx[i] = 8'($urandom);
    host_u.xfer(n, tx, rx);
    for (int i = 2; i * 8 + 8 <= n && (b || i == 2); i++)
    begin
      x = a + 8'(i - 2);
      if (rd)
        cmp("read_byte", shadow[x], rx[i]);
      else
        shadow[x] = tx[i];
    end
    repeat (8) @(posedge ref_clk);
    cmp("miso_oe", 8'h00, 8'(miso_oe));
  endtask

  // Register file must hold exactly what whole write bytes put there
  task automatic sweep();
    for (int i = 0; i < 256; i++)
      cmp("reg_file", shadow[i], mem[i]);
  endtask

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  // Main sequence
  initial
  begin
    logic [7:0] a;
    nrst = 1'b0;
    sel = 2'h2;
    par_t = 1'b0;
    cpol = 1'b0;
    cpha = 1'b0;
    rd_data = 8'h00;
    void'($urandom(98843));
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'($urandom);
      shadow[i] = mem[i];
    end
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // Every strap code with both bus styles
    for (int m = 0; m < 8; m++)
    begin
      sel <= m[1:0];
      par_t <= m[2];
      repeat (2) @(posedge ref_clk);
      cmp("port_mode", 8'(m % 4), 8'(mode));
      cmp("bus_style", 8'(m / 4), 8'(style));
    end
    sel <= 2'h2;
    // All clock modes twice: extra, burst, wrapping and cut-short frames
    for (int k = 0; k < 8; k++)
    begin
      cpol <= k[1];
      cpha <= k[0];
      a = 8'($urandom);
      frame(1'b0, a, 1'b0, 40);
      frame(1'b1, a, 1'b0, 24);
      frame(1'b0, 8'hFE, 1'b1, 48);
      frame(1'b0, a + 8'h01, 1'b0, 20);
      rd_cnt = 0;
      frame(1'b1, 8'hFE, 1'b1, 44);
      cmp("prefetch", 8'h04, 8'(rd_cnt));
    end
    sweep();
    // Reset in mid-run returns the decode to hardware pin mode
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp("reset_mode", 8'h03, 8'(mode));
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // A frame outside serial mode must not write
    sel <= 2'h1;
    {tx[0], tx[1]} = cmd(1'b0, 8'h33, 1'b0);
    tx[2] = ~shadow[8'h33];
    host_u.xfer(24, tx, rx);
    sweep();
    results();
  end
endmodule
